// ### design/csrp_pkg.sv
// constants and types shared by both ends of the clock synthesizer register port
// assumes one port clock for both ends; no reset is documented on the port itself
//
// Overview of operation
// [R1] all port signals referenced to port clock rise
// [R2] unused feature: controller holds strobe low
// [R3] strobe with write select stores write data
// [R4] no writes: controller ties write select low
// [R5] address bus seven bits, locations 0..127
// [R6] unused port: controller drives address zero; the controller keeps the last access address
// [R7] unused port: controller drives write data zero; the controller keeps the last write data
// [R8] write data sixteen bits, whole word stored
// [R9] addressed register shown on 16-bit read data
// [R10] one acknowledge pulse per strobed access
// [R11] read data captured at ack, held stable
// [R12] no new access before previous acknowledge
// [R13] strobe lasts exactly one port clock cycle
// [R14] output phase within one cycle, divider steps
// [R15] feedback phase shifts outputs negatively, multiplier steps
// [R16] compensation stays automatic, alternatives never chosen; the device stores any value and flags non-auto ones on comp_error
// [R17] phy clock twice, equal or half oscillator
// [R18] strobe during pending access is ignored
package csrp_pkg;
    localparam int ADDR_W = 7;
    localparam int DATA_W = 16;
    localparam int REGS   = 128;
    // internal register locations used by the device's own decode
    localparam logic [6:0] ADDR_OUT0_PHASE = 7'h08;
    localparam logic [6:0] ADDR_OUT1_PHASE = 7'h0a;
    localparam logic [6:0] ADDR_PHY_RATIO  = 7'h0b;
    localparam logic [6:0] ADDR_FB_PHASE   = 7'h14;
    localparam logic [6:0] ADDR_COMP       = 7'h05;
    localparam logic [6:0] ADDR_OUT_DIV    = 7'h09;
    localparam logic [6:0] ADDR_FB_MULT    = 7'h15;
    // phase fields are signed steps; one full cycle = divider steps for outputs, multiplier steps for feedback
    localparam int PHASE_W = 9;
    localparam logic [15:0] RST_OUT_DIV = 16'h0001;
    localparam logic [15:0] RST_FB_MULT = 16'h0005;
    localparam logic [15:0] RST_ZERO    = 16'h0000;
    // access latency of the device, strobe edge to ack
    localparam int ACK_LAT = 2;
    localparam logic [1:0] ACK_LAT_M1 = 2'h1;
    // register indexes (paddr[4:2]) of the controller's own registers, and the read value of a bad access
    localparam logic [2:0] APB_CMD   = 3'h0;
    localparam logic [2:0] APB_WDATA = 3'h1;
    localparam logic [2:0] APB_STAT  = 3'h2;
    localparam logic [2:0] APB_RDATA = 3'h3;
    localparam logic [31:0] APB_BAD = 32'h0000_0000;
    typedef enum logic [1:0] {
        CSRP_PHY_TWICE = 2'b00,
        CSRP_PHY_EQUAL = 2'b01,
        CSRP_PHY_HALF  = 2'b10
    } csrp_phy_t;
    typedef enum logic [1:0] {
        CSRP_COMP_AUTO     = 2'b00,
        CSRP_COMP_ALIGN    = 2'b01,
        CSRP_COMP_BUF_IN   = 2'b10,
        CSRP_COMP_INTERNAL = 2'b11
    } csrp_comp_t;
endpackage

// ### design/csrp_if.sv
// port between the synthesizer register bank and its controller
// assumes both ends clocked by port_clk
`timescale 1ns/1ps
`default_nettype none
interface csrp_if (input wire logic port_clk);
    logic        access_strobe;
    logic        write_select;
    logic [6:0]  config_addr;
    logic [15:0] config_wdata;
    logic [15:0] config_rdata;
    logic        access_ack;
    modport device (
        input  port_clk, access_strobe, write_select, config_addr, config_wdata,
        output config_rdata, access_ack
    );
    modport ctrl (
        output access_strobe, write_select, config_addr, config_wdata,
        input  config_rdata, access_ack
    );
endinterface
`default_nettype wire

// ### design/csrp_device.sv
// register bank end of the synthesizer port, with derived clock settings
// assumes controller keeps one-cycle strobes and waits for ack
//
// The APB interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module csrp_device (
    // reset; the clock comes with the port
    input  wire logic        presetn,
    // port
    csrp_if.device           port,
    // derived settings
    output logic [8:0]       out0_phase,
    output logic [8:0]       out1_phase,
    output logic [8:0]       fb_phase,
    output logic [1:0]       phy_clk_ratio_sel,
    output logic             comp_error
);
    // ****************************************
    // storage and access pipeline
    // ****************************************
    logic [15:0] regs [0:127];
    logic [15:0] next_regs [0:127];
    logic        busy, next_busy;
    logic [1:0]  cnt, next_cnt;
    logic        pend_we, next_pend_we;
    logic [6:0]  pend_addr, next_pend_addr;
    logic [15:0] pend_data, next_pend_data;
    logic [15:0] rdata, next_rdata;
    logic        ack, next_ack;

    // signed phase clamped to one cycle: range [-lim, +lim] steps
    function automatic logic [8:0] clamp_phase(input logic [15:0] v, input logic [15:0] lim);
        logic signed [15:0] s;
        logic signed [15:0] l;
        s = v;
        l = lim;
        if (s > l) clamp_phase = l[8:0];
        else if (s < -l) clamp_phase = 9'(-l);
        else clamp_phase = s[8:0];
    endfunction

    always_comb begin
        next_regs      = regs;
        next_busy      = busy;
        next_cnt       = cnt;
        next_pend_we   = pend_we;
        next_pend_addr = pend_addr;
        next_pend_data = pend_data;
        next_rdata     = rdata;
        next_ack       = 1'b0;
        if (!busy) begin
            if (port.access_strobe) begin // R1
                next_busy      = 1'b1;
                // take edge counts as the first latency cycle
                next_cnt       = 2'h1;
                next_pend_we   = port.write_select;
                next_pend_addr = port.config_addr; // R5
                next_pend_data = port.config_wdata; // R8
            end
        end else if (cnt == csrp_pkg::ACK_LAT_M1) begin
            // strobes while busy fall here and are dropped
            next_busy = 1'b0; // R18
            next_ack  = 1'b1; // R10
            if (pend_we) begin
                next_regs[pend_addr] = pend_data; // R3
            end else begin
                next_rdata = regs[pend_addr]; // R9 R11
            end
        end else begin
            next_cnt = cnt + 2'h1;
        end
    end

    always_ff @(posedge port.port_clk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < csrp_pkg::REGS; i++) begin
                regs[i] <= csrp_pkg::RST_ZERO;
            end
            regs[csrp_pkg::ADDR_OUT_DIV] <= csrp_pkg::RST_OUT_DIV;
            regs[csrp_pkg::ADDR_FB_MULT] <= csrp_pkg::RST_FB_MULT;
            busy      <= 1'b0;
            cnt       <= 2'h0;
            pend_we   <= 1'b0;
            pend_addr <= 7'h00;
            pend_data <= 16'h0000;
            rdata     <= 16'h0000;
            ack       <= 1'b0;
        end else begin
            regs      <= next_regs;
            busy      <= next_busy;
            cnt       <= next_cnt;
            pend_we   <= next_pend_we;
            pend_addr <= next_pend_addr;
            pend_data <= next_pend_data;
            rdata     <= next_rdata;
            ack       <= next_ack;
        end
    end

    assign port.config_rdata = rdata;
    assign port.access_ack   = ack;

    // ****************************************
    // derived clock settings
    // ****************************************
    logic [8:0] next_out0, next_out1, next_fb;
    logic [1:0] next_phy;
    logic       next_comp_err;

    always_comb begin
        next_out0 = clamp_phase(regs[csrp_pkg::ADDR_OUT0_PHASE],
                                regs[csrp_pkg::ADDR_OUT_DIV]); // R14
        next_out1 = clamp_phase(regs[csrp_pkg::ADDR_OUT1_PHASE],
                                regs[csrp_pkg::ADDR_OUT_DIV]); // R14
        // feedback shift moves every output the other way
        next_fb = 9'(-clamp_phase(regs[csrp_pkg::ADDR_FB_PHASE],
                                  regs[csrp_pkg::ADDR_FB_MULT])); // R15
        case (regs[csrp_pkg::ADDR_PHY_RATIO][1:0]) // R17
            csrp_pkg::CSRP_PHY_EQUAL: next_phy = csrp_pkg::CSRP_PHY_EQUAL;
            csrp_pkg::CSRP_PHY_HALF:  next_phy = csrp_pkg::CSRP_PHY_HALF;
            default:                  next_phy = csrp_pkg::CSRP_PHY_TWICE;
        endcase
        next_comp_err = regs[csrp_pkg::ADDR_COMP][1:0] != csrp_pkg::CSRP_COMP_AUTO; // R16
    end

    always_ff @(posedge port.port_clk or negedge presetn) begin
        if (!presetn) begin
            out0_phase        <= 9'h000;
            out1_phase        <= 9'h000;
            fb_phase          <= 9'h000;
            phy_clk_ratio_sel <= csrp_pkg::CSRP_PHY_TWICE;
            comp_error        <= 1'b0;
        end else begin
            out0_phase        <= next_out0;
            out1_phase        <= next_out1;
            fb_phase          <= next_fb;
            phy_clk_ratio_sel <= next_phy;
            comp_error        <= next_comp_err;
        end
    end
endmodule
`default_nettype wire

// ### design/csrp_ctrl.sv
// controller end: APB slave that issues single port accesses
// assumes pclk is also the port clock
`timescale 1ns/1ps
`default_nettype none
module csrp_ctrl (
    // apb
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // port
    csrp_if.ctrl             port
);
    typedef enum logic [1:0] {
        CSRP_IDLE = 2'b00,
        CSRP_STRB = 2'b01,
        CSRP_WAIT = 2'b10
    } csrp_state_t;

    csrp_state_t state, next_state;
    logic        we, next_we;
    logic [6:0]  addr, next_addr;
    logic [15:0] wdata, next_wdata;
    logic [15:0] rdata, next_rdata;
    logic        strb, next_strb;
    logic [31:0] next_prdata;
    logic        next_pready, next_pslverr;
    logic        acc;
    logic [2:0]  idx;

    assign acc = psel && penable && !pready;
    assign idx = paddr[4:2];

    always_comb begin
        next_state   = state;
        next_we      = we;
        next_addr    = addr;
        next_wdata   = wdata;
        next_rdata   = rdata;
        next_strb    = 1'b0;
        next_prdata  = prdata;
        next_pready  = 1'b0;
        next_pslverr = 1'b0;
        case (state)
            CSRP_IDLE: ;
            CSRP_STRB: next_state = CSRP_WAIT;
            CSRP_WAIT: begin
                if (port.access_ack) begin // R12
                    next_rdata = port.config_rdata; // R11
                    next_we    = 1'b0; // R4
                    next_state = CSRP_IDLE;
                end
            end
            default: next_state = CSRP_IDLE;
        endcase
        if (acc) begin
            next_pready = 1'b1;
            if (idx == csrp_pkg::APB_CMD && pwrite) begin
                if (state == CSRP_IDLE) begin
                    next_we    = pwdata[16];
                    next_addr  = pwdata[6:0]; // R5
                    next_strb  = 1'b1; // R13
                    next_state = CSRP_STRB;
                end else begin
                    next_pslverr = 1'b1;
                end
            end else if (idx == csrp_pkg::APB_WDATA) begin
                if (pwrite) next_wdata = pwdata[15:0]; // R8
                next_prdata = {16'h0000, wdata};
            end else if (idx == csrp_pkg::APB_STAT && !pwrite) begin
                next_prdata = {31'h0000_0000, state != CSRP_IDLE};
            end else if (idx == csrp_pkg::APB_RDATA && !pwrite) begin
                next_prdata = {16'h0000, rdata};
            end else begin
                next_prdata  = csrp_pkg::APB_BAD;
                next_pslverr = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // port at reset: strobe, select, address and data all zero
            state   <= CSRP_IDLE; // R2 R6 R7
            we      <= 1'b0;
            addr    <= 7'h00;
            wdata   <= 16'h0000;
            rdata   <= 16'h0000;
            strb    <= 1'b0;
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            state   <= next_state;
            we      <= next_we;
            addr    <= next_addr;
            wdata   <= next_wdata;
            rdata   <= next_rdata;
            strb    <= next_strb;
            prdata  <= next_prdata;
            pready  <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    assign port.access_strobe = strb; // R1
    assign port.write_select  = we;
    assign port.config_addr   = addr;
    assign port.config_wdata  = wdata;
endmodule
`default_nettype wire

// ### tb/csrp_asserts.sv
// concurrent checks on the port between register bank and controller
// assumes instantiation beside the interface, one port clock
`timescale 1ns/1ps
`default_nettype none
module csrp_asserts (
    // clock and reset
    input wire logic        port_clk,
    input wire logic        presetn,
    // port
    input wire logic        access_strobe,
    input wire logic        write_select,
    input wire logic [6:0]  config_addr,
    input wire logic [15:0] config_wdata,
    input wire logic [15:0] config_rdata,
    input wire logic        access_ack
);
    // ************************************************
    // port timing
    // ************************************************
    default clocking cb @(posedge port_clk); endclocking
    default disable iff (!presetn);

    a_ack_latency: assert property (access_strobe |-> ##2 access_ack)
        else $error("ack missing two cycles after strobe");
    a_ack_no_early: assert property (access_strobe |=> !access_ack)
        else $error("ack one cycle after strobe");
    a_ack_has_cause: assert property (access_ack |-> $past(access_strobe, 2))
        else $error("ack without a strobe two cycles earlier");
    a_ack_one_cycle: assert property (access_ack |=> !access_ack)
        else $error("ack longer than one cycle");
    a_strobe_single: assert property (access_strobe |=> !access_strobe)
        else $error("strobe longer than one cycle");
    a_strobe_waits_ack: assert property (access_strobe |-> ##2 !access_strobe)
        else $error("strobe before previous ack");
    a_rdata_at_ack: assert property ($changed(config_rdata) |-> access_ack)
        else $error("read data changed outside an ack");
    a_write_keeps_rdata: assert property (
        access_strobe && write_select |-> ##2 $stable(config_rdata))
        else $error("write access disturbed read data");

    // top address and full data word seen on a write
    c_write_top: cover property (access_strobe && write_select && config_addr == 7'h7f
        && config_wdata == 16'hffff);
    c_read: cover property (access_strobe && !write_select ##2 access_ack);
    c_spaced: cover property (access_ack ##[1:40] access_strobe);
endmodule
`default_nettype wire

// ### tb/clock_synth_reconfig_port_test.sv
// self-checking bench: apb software view down to the register bank
// assumes both ends share pclk as port clock
`timescale 1ns/1ps
`default_nettype none
module clock_synth_reconfig_port_test;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [8:0]  out0_phase;
    logic [8:0]  out1_phase;
    logic [8:0]  fb_phase;
    logic [1:0]  phy_clk_ratio_sel;
    logic        comp_error;
    logic [15:0] mdl [128];
    logic [31:0] r;
    logic [31:0] rn;
    logic        e;
    logic [6:0]  a;
    int          bad_count = 0;
    int          comparisons = 0;
    int          cyc = 0;
    int          seed = 48;

    always #12.5 pclk = ~pclk;

    csrp_if i_csrp_if (.port_clk(pclk));
    csrp_device i_csrp_device (.presetn(presetn), .port(i_csrp_if.device),
        .out0_phase(out0_phase), .out1_phase(out1_phase), .fb_phase(fb_phase),
        .phy_clk_ratio_sel(phy_clk_ratio_sel), .comp_error(comp_error));
    csrp_ctrl i_csrp_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .port(i_csrp_if.ctrl));
    csrp_asserts i_csrp_asserts (.port_clk(pclk), .presetn(presetn),
        .access_strobe(i_csrp_if.access_strobe), .write_select(i_csrp_if.write_select),
        .config_addr(i_csrp_if.config_addr), .config_wdata(i_csrp_if.config_wdata),
        .config_rdata(i_csrp_if.config_rdata), .access_ack(i_csrp_if.access_ack));

    // ************************************************
    // tasks
    // ************************************************
    task automatic tally_and_finish;
        if (bad_count == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        comparisons++;
        if (g !== x) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask

    // request held until pready is sampled high
    task automatic apb(input logic w, input logic [31:0] ad, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= ad;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // pready high ends this wait; if it never comes, only the bench timeout does
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // one port access, then poll busy until the ack has come back
    task automatic acc(input logic w, input logic [6:0] ad, input logic [15:0] dd);
        apb(1'b1, 32'h4, {16'h0, dd});
        apb(1'b1, 32'h0, {15'h0, w, 9'h0, ad});
        do begin
            apb(1'b0, 32'h8, 32'h0);
        end while (r[0] !== 1'b0);
        if (w) begin
            mdl[ad] = dd;
        end
    endtask

    task automatic rd(input logic [6:0] ad);
        rn = $random(seed);
        acc(1'b0, ad, rn[15:0]);
        apb(1'b0, 32'hc, 32'h0);
        chk(r, {16'h0, mdl[ad]});
    endtask

    // one cycle of offset is lim steps either way; feedback shift inverted
    function automatic logic [31:0] want_phase(input logic [15:0] v, input logic [15:0] lim,
                                               input logic neg);
        int s;
        int l;
        s = $signed(v);
        l = $signed(lim);
        if (s > l) s = l;
        if (s < -l) s = -l;
        if (neg) s = -s;
        want_phase = {23'h0, s[8:0]};
    endfunction

    function automatic logic [31:0] want_ratio(input logic [15:0] v);
        if (v[1:0] == 2'h1) want_ratio = {30'h0, csrp_pkg::CSRP_PHY_EQUAL};
        else if (v[1:0] == 2'h2) want_ratio = {30'h0, csrp_pkg::CSRP_PHY_HALF};
        else want_ratio = {30'h0, csrp_pkg::CSRP_PHY_TWICE};
    endfunction

    // write one settings register, then compare every derived output
    task automatic set_chk(input logic [6:0] ad, input logic [15:0] dd);
        logic [15:0] dv;
        logic [15:0] fm;
        acc(1'b1, ad, dd);
        dv = mdl[csrp_pkg::ADDR_OUT_DIV];
        fm = mdl[csrp_pkg::ADDR_FB_MULT];
        chk({23'h0, out0_phase}, want_phase(mdl[csrp_pkg::ADDR_OUT0_PHASE], dv, 1'b0));
        chk({23'h0, out1_phase}, want_phase(mdl[csrp_pkg::ADDR_OUT1_PHASE], dv, 1'b0));
        chk({23'h0, fb_phase}, want_phase(mdl[csrp_pkg::ADDR_FB_PHASE], fm, 1'b1));
        chk({30'h0, phy_clk_ratio_sel}, want_ratio(mdl[csrp_pkg::ADDR_PHY_RATIO]));
        chk({31'h0, comp_error}, {31'h0, mdl[csrp_pkg::ADDR_COMP][1:0] != 2'h0});
    endtask

    // ************************************************
    // sequence
    // ************************************************
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            bad_count++;
            tally_and_finish;
        end
    end

    initial begin
        for (int i = 0; i < 128; i++) begin
            mdl[i] = 16'h0;
        end
        mdl[csrp_pkg::ADDR_OUT_DIV] = csrp_pkg::RST_OUT_DIV;
        mdl[csrp_pkg::ADDR_FB_MULT] = csrp_pkg::RST_FB_MULT;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk({30'h0, phy_clk_ratio_sel}, {30'h0, csrp_pkg::CSRP_PHY_TWICE});
        chk({31'h0, comp_error}, 32'h0);
        chk({7'h0, i_csrp_if.access_strobe, i_csrp_if.write_select, i_csrp_if.config_addr,
             i_csrp_if.config_wdata}, 32'h0);
        rd(csrp_pkg::ADDR_OUT_DIV);
        rd(csrp_pkg::ADDR_FB_MULT);
        acc(1'b1, 7'h7f, 16'hffff);
        acc(1'b1, 7'h00, 16'h0000);
        rd(7'h7f);
        rd(7'h00);
        // settings registers feed the derived outputs, so random data stays off them
        for (int i = 0; i < 30; i++) begin
            rn = $random(seed);
            a = rn[6:0];
            if (a inside {7'h05, 7'h08, 7'h09, 7'h0a, 7'h0b, 7'h14, 7'h15}) begin
                a = a ^ 7'h40;
            end
            if (rn[20]) begin
                acc(1'b1, a, rn[31:16]);
            end
            rd(a);
        end
        // settings: clamp against divider and multiplier, ratio and compensation decode
        set_chk(csrp_pkg::ADDR_OUT0_PHASE, 16'hfffd);
        set_chk(csrp_pkg::ADDR_OUT1_PHASE, 16'h0001);
        set_chk(csrp_pkg::ADDR_FB_PHASE, 16'h0002);
        set_chk(csrp_pkg::ADDR_OUT_DIV, 16'h0004);
        set_chk(csrp_pkg::ADDR_OUT0_PHASE, 16'h0009);
        set_chk(csrp_pkg::ADDR_FB_PHASE, 16'hfff0);
        for (int i = 1; i < 4; i++) begin
            set_chk(csrp_pkg::ADDR_PHY_RATIO, 16'(i));
            set_chk(csrp_pkg::ADDR_COMP, 16'(i));
        end
        set_chk(csrp_pkg::ADDR_COMP, 16'h0000);
        rd(7'h7f);
        acc(1'b1, 7'h01, 16'h5a5a);
        apb(1'b0, 32'hc, 32'h0);
        chk(r, {16'h0, mdl[7'h7f]});
        apb(1'b0, 32'h10, 32'h0);
        chk({31'h0, e}, 32'h1);
        chk(r, csrp_pkg::APB_BAD);
        tally_and_finish;
    end
endmodule
`default_nettype wire
